// [pchco_pkg.sv]
// Purpose: Constants for the PCI host clock output block
// Assumes: Register bus is AHB-Lite, 32-bit words, hclk at 250 MHz
// Notes:   Every offset, field, reset value and count is named here
//
// Function
// (R1) With host mode selected the primary input clock is the source.
// (R2) The primary clock feeds a divide-by-2 stage and the output muxes.
// (R3) The divide select input picks the full or halved clock for sync out.
// (R4) The board loops the sync output back to the sync input.
// (R5) Three separate PCI clock outputs, index 0 to 2, serve outside agents.
// (R6) After reset every PCI clock output is driven steadily low.
// (R7) Each output toggles only once its own enable bit is set.
// (R8) All enabled PCI clock outputs are phase-aligned to one another.
// (R9) In agent mode the PCI clock outputs and sync output are unused.
// (R10) Gating changes only while the source clock is low.
package pchco_pkg;

	localparam int          NUM_OUTPUTS    = 3;
	localparam int          ADDR_LSB       = 2;
	localparam int          ADDR_W         = 4;

	// Register byte offsets
	localparam logic [3:0]  OCC_OFF        = 4'h0;
	localparam logic [3:0]  STATUS_OFF     = 4'h4;

	// Output clock control fields
	localparam int          OCC_EN_LSB     = 0;
	localparam logic [2:0]  OCC_RST        = 3'h0;

	// Status fields
	localparam int          ST_HOST_BIT    = 0;
	localparam int          ST_DIV_BIT     = 1;
	localparam int          ST_GATE_LSB    = 2;
	localparam int          ST_SRC_BIT     = 5;

	// Strap capture waits for the pin synchronisers to fill
	localparam logic [1:0]  STRAP_SETTLE   = 2'h2;

	// AHB-Lite encodings
	localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
	localparam logic        HRESP_OKAY     = 1'h0;

	typedef enum logic [1:0]
	{
		STRAP_WAIT = 2'b01,
		STRAP_DONE = 2'b10
	} pchco_strap_t;

endpackage

// [pchco_top.sv]
// Purpose: PCI host clock outputs with AHB-Lite control registers
// Assumes: Primary input clock is far slower than hclk and is sampled
// Notes:   All clock outputs are flops of hclk, so edges move by 4 ns steps
//
// Added by the designer: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps

module pchco_top
#(
	parameter int N_OUT = pchco_pkg::NUM_OUTPUTS
)
(
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic      [31:0]       hrdata,
	output logic                   hresp,
	input  wire logic              primary_input_clock,
	input  wire logic              host_mode_select,
	input  wire logic              input_divide_select,
	output logic                   sync_clock_out,
	output logic      [N_OUT-1:0]  pci_clock_out
);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: clock pin and two straps

	logic [2:0]               pin_meta_r;
	logic [2:0]               pin_sync_r;
	logic [2:0]               pin_meta_nxt;
	logic [2:0]               pin_sync_nxt;

	always_comb
	begin
		pin_meta_nxt = {input_divide_select, host_mode_select,
			primary_input_clock};
		pin_sync_nxt = pin_meta_r;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pin_meta_r <= 3'h0;
			pin_sync_r <= 3'h0;
		end
		else
		begin
			pin_meta_r <= pin_meta_nxt;
			pin_sync_r <= pin_sync_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Strap capture after reset release

	pchco_pkg::pchco_strap_t  strap_st_r;
	pchco_pkg::pchco_strap_t  strap_st_nxt;
	logic [1:0]               strap_cnt_r;
	logic [1:0]               strap_cnt_nxt;
	logic                     host_mode_r;
	logic                     host_mode_nxt;
	logic                     div_sel_r;
	logic                     div_sel_nxt;

	always_comb
	begin
		strap_st_nxt  = strap_st_r;
		strap_cnt_nxt = strap_cnt_r;
		host_mode_nxt = host_mode_r;
		div_sel_nxt   = div_sel_r;
		case (strap_st_r)
			pchco_pkg::STRAP_WAIT:
			begin
				if (strap_cnt_r == pchco_pkg::STRAP_SETTLE)
				begin
					host_mode_nxt = pin_sync_r[1];
					div_sel_nxt   = pin_sync_r[2];
					strap_st_nxt  = pchco_pkg::STRAP_DONE;
				end
				else
				begin
					strap_cnt_nxt = strap_cnt_r + 2'h1;
				end
			end
			pchco_pkg::STRAP_DONE:
			begin
				strap_st_nxt = pchco_pkg::STRAP_DONE;
			end
			default:
			begin
				strap_st_nxt = pchco_pkg::STRAP_WAIT;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			strap_st_r  <= pchco_pkg::STRAP_WAIT;
			strap_cnt_r <= 2'h0;
			host_mode_r <= 1'b0;
			div_sel_r   <= 1'b0;
		end
		else
		begin
			strap_st_r  <= strap_st_nxt;
			strap_cnt_r <= strap_cnt_nxt;
			host_mode_r <= host_mode_nxt;
			div_sel_r   <= div_sel_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave, zero wait states

	logic                     wr_pend_r;
	logic                     wr_pend_nxt;
	logic [3:0]               wr_addr_r;
	logic [3:0]               wr_addr_nxt;
	logic [N_OUT-1:0]         occ_en_r;
	logic [N_OUT-1:0]         occ_en_nxt;
	logic [31:0]              hrdata_nxt;
	logic [N_OUT-1:0]         occ_view;
	logic [N_OUT-1:0]         gate_r;
	logic                     src_r;
	logic                     addr_ok;

	always_comb
	begin
		addr_ok     = hsel && hready && (htrans == pchco_pkg::HTRANS_NONSEQ);
		wr_pend_nxt = addr_ok && hwrite;
		wr_addr_nxt = addr_ok ? haddr[3:0] : wr_addr_r;
		occ_en_nxt  = occ_en_r;
		if (wr_pend_r && (wr_addr_r == pchco_pkg::OCC_OFF))
		begin
			occ_en_nxt = hwdata[pchco_pkg::OCC_EN_LSB +: N_OUT];    // R7
		end
		// Forward a write in flight so a back-to-back read sees it
		occ_view   = occ_en_nxt;
		hrdata_nxt = hrdata;
		if (addr_ok && !hwrite)
		begin
			hrdata_nxt = 32'h0;
			case (haddr[3:0])
				pchco_pkg::OCC_OFF:
				begin
					hrdata_nxt[pchco_pkg::OCC_EN_LSB +: N_OUT] = occ_view;
				end
				pchco_pkg::STATUS_OFF:
				begin
					hrdata_nxt[pchco_pkg::ST_HOST_BIT] = host_mode_r;
					hrdata_nxt[pchco_pkg::ST_DIV_BIT]  = div_sel_r;
					hrdata_nxt[pchco_pkg::ST_GATE_LSB +: N_OUT] = gate_r;
					hrdata_nxt[pchco_pkg::ST_SRC_BIT]  = src_r;
				end
				default:
				begin
					hrdata_nxt = 32'h0;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 4'h0;
			occ_en_r  <= N_OUT'(pchco_pkg::OCC_RST);                // R6
			hrdata    <= 32'h0;
			hreadyout <= 1'b1;
			hresp     <= pchco_pkg::HRESP_OKAY;
		end
		else
		begin
			wr_pend_r <= wr_pend_nxt;
			wr_addr_r <= wr_addr_nxt;
			occ_en_r  <= occ_en_nxt;
			hrdata    <= hrdata_nxt;
			hreadyout <= 1'b1;
			hresp     <= pchco_pkg::HRESP_OKAY;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Divider, source mux and sync output

	logic                     clk_prev_r;
	logic                     half_r;
	logic                     half_nxt;
	logic                     src_nxt;
	logic                     sync_nxt;
	logic                     active;

	always_comb
	begin
		// Agent mode: outputs unused, held low
		active   = host_mode_r && (strap_st_r == pchco_pkg::STRAP_DONE); // R1 R9
		half_nxt = half_r;
		if (pin_sync_r[0] && !clk_prev_r)
		begin
			half_nxt = !half_r;                                     // R2
		end
		// One source for sync and PCI outputs keeps them in step
		src_nxt  = active && (div_sel_r ? half_nxt : pin_sync_r[0]); // R3
		sync_nxt = src_nxt;                                         // R4
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			clk_prev_r     <= 1'b0;
			half_r         <= 1'b0;
			src_r          <= 1'b0;
			sync_clock_out <= 1'b0;
		end
		else
		begin
			clk_prev_r     <= pin_sync_r[0];
			half_r         <= half_nxt;
			src_r          <= src_nxt;
			sync_clock_out <= sync_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per-output glitch-free gates

	genvar g;
	generate
		for (g = 0; g < N_OUT; g = g + 1)
		begin : gen_out
			logic gate_nxt;
			logic out_nxt;

			always_comb
			begin
				// Gate moves only while the source is low: no runt pulse
				gate_nxt = src_nxt ? gate_r[g] : (occ_en_r[g] && active); // R10
				// Same source edge for every output, no per-output skew
				out_nxt  = src_nxt && gate_nxt;                     // R5 R8
			end

			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
				begin
					gate_r[g]        <= 1'b0;
					pci_clock_out[g] <= 1'b0;                       // R6
				end
				else
				begin
					gate_r[g]        <= gate_nxt;
					pci_clock_out[g] <= out_nxt;                    // R7
				end
			end
		end
	endgenerate

endmodule

// [pchco_top_asserts.sv]
// Purpose: Port checks on the PCI host clock outputs
// Assumes: Straps change only while reset is held
// Notes:   Bound into pchco_top
`timescale 1ns/1ps
module pchco_chk
#(
	parameter int N_OUT = 3
)
(
	input wire logic             hclk,
	input wire logic             hresetn,
	input wire logic             hreadyout,
	input wire logic             hresp,
	input wire logic             primary_input_clock,
	input wire logic             host_mode_select,
	input wire logic             input_divide_select,
	input wire logic             sync_clock_out,
	input wire logic [N_OUT-1:0] pci_clock_out
);
	logic [3:0] up_r;
	logic [3:0] up_nxt;
	logic       ok;
	// Straps are only trusted once latched
	always_comb up_nxt = up_r + {3'h0, ~&up_r};
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			up_r <= 4'h0;
		else
			up_r <= up_nxt;
	assign ok = &up_r;
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	////////////////////////////////////////
	property p_okay;
		hreadyout && !hresp;
	endproperty
	a_okay: assert property (p_okay)
		else $error("bus stall or error");
	property p_rst_low;
		$rose(hresetn) |-> (pci_clock_out == '0) [*4];
	endproperty
	a_rst_low: assert property (p_rst_low)
		else $error("clock out after reset");
	property p_align;
		!(|(pci_clock_out & ~{N_OUT{sync_clock_out}}));
	endproperty
	a_align: assert property (p_align)
		else $error("output not aligned");
	property p_gate;
		$changed(pci_clock_out) |-> $changed(sync_clock_out);
	endproperty
	a_gate: assert property (p_gate)
		else $error("short pulse");
	property p_div0;
		ok && host_mode_select && !input_divide_select &&
			$rose(primary_input_clock) |-> ##[1:6] $rose(sync_clock_out);
	endproperty
	a_div0: assert property (p_div0)
		else $error("sync missed rise");
	property p_div1;
		ok && host_mode_select && input_divide_select &&
			$rose(primary_input_clock) |-> ##[1:6] $changed(sync_clock_out);
	endproperty
	a_div1: assert property (p_div1)
		else $error("halved sync missed");
	property p_src;
		ok && $stable(primary_input_clock) [*4] |-> $stable(sync_clock_out);
	endproperty
	a_src: assert property (p_src)
		else $error("sync moved alone");
	property p_agent;
		ok && !host_mode_select |-> !sync_clock_out && pci_clock_out == '0;
	endproperty
	a_agent: assert property (p_agent)
		else $error("agent mode output");
	cover property (ok && $rose(sync_clock_out));
	cover property (ok && &pci_clock_out);
	cover property (ok && !host_mode_select);
endmodule
bind pchco_top pchco_chk #(.N_OUT(N_OUT)) chk
(
	.hclk                (hclk),
	.hresetn             (hresetn),
	.hreadyout           (hreadyout),
	.hresp               (hresp),
	.primary_input_clock (primary_input_clock),
	.host_mode_select    (host_mode_select),
	.input_divide_select (input_divide_select),
	.sync_clock_out      (sync_clock_out),
	.pci_clock_out       (pci_clock_out)
);

// [pchco_agent.sv]
// Purpose: Board oscillator and PCI agent edge counters
// Assumes: Oscillator steps on hclk edges
// Notes:   rises[3] counts the sync loop back
`timescale 1ns/1ps
module pchco_agent
#(
	parameter int HALF = 8
)
(
	input  wire logic       hclk,
	input  wire logic       sync_clock_out,
	input  wire logic [2:0] pci_clock_out,
	output logic            primary_input_clock,
	output logic [7:0]      rises [4]
);
	logic [3:0] now;
	logic [3:0] prev = 4'h0;
	int         t = 0;
	assign now = {sync_clock_out, pci_clock_out};
	initial primary_input_clock = 1'b0;
	initial rises = '{default: 8'h0};
	always @(posedge hclk)
	begin
		t <= (t == HALF - 1) ? 0 : t + 1;
		if (t == HALF - 1)
			primary_input_clock <= ~primary_input_clock;
		prev <= now;
		for (int i = 0; i < 4; i++)
			if (now[i] && !prev[i])
				rises[i] <= rises[i] + 8'h1;
	end
endmodule

// [pchco_top_bench.sv]
// Purpose: Self-checking bench for pchco_top
// Assumes: Single slave, hready from hreadyout
// Notes:   Edges counted over 64-cycle windows
`timescale 1ns/1ps
module pchco_top_bench;
	typedef struct {logic [2:0] en; logic [31:0] exp;} pchco_row_t;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0]  htrans = '0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = '0;
	logic        hready;
	logic        hreadyout;
	logic [31:0] hrdata;
	logic        hresp;
	logic        primary_input_clock;
	logic        host_mode_select = 1'b1;
	logic        input_divide_select = 1'b0;
	logic        sync_clock_out;
	logic [2:0]  pci_clock_out;
	logic [7:0]  rises [4];
	logic [7:0]  base [4];
	logic [31:0] rd;
	int          error_cnt = 0;
	int          compares = 0;
	pchco_row_t  rows [6] = '{'{3'h1, 32'h1}, '{3'h2, 32'h2},
		'{3'h4, 32'h4}, '{3'h5, 32'h5}, '{3'h0, 32'h0}, '{3'h7, 32'h7}};
	assign hready = hreadyout;
	always #2 hclk = ~hclk;
	pchco_top dut
	(
		.hclk                (hclk),
		.hresetn             (hresetn),
		.hsel                (hsel),
		.haddr               (haddr),
		.htrans              (htrans),
		.hwrite              (hwrite),
		.hsize               (hsize),
		.hwdata              (hwdata),
		.hready              (hready),
		.hreadyout           (hreadyout),
		.hrdata              (hrdata),
		.hresp               (hresp),
		.primary_input_clock (primary_input_clock),
		.host_mode_select    (host_mode_select),
		.input_divide_select (input_divide_select),
		.sync_clock_out      (sync_clock_out),
		.pci_clock_out       (pci_clock_out)
	);
	pchco_agent agent
	(
		.hclk                (hclk),
		.sync_clock_out      (sync_clock_out),
		.pci_clock_out       (pci_clock_out),
		.primary_input_clock (primary_input_clock),
		.rises               (rises)
	);
	////////////////////////////////////////
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic print_verdict();
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wt();
		int k;
		k = 0;
		do
		begin
			@(posedge hclk);
			k++;
		end
		while (hready !== 1'b1 && k < 20);
		if (hready !== 1'b1)
		begin
			error_cnt++;
			print_verdict();
		end
	endtask
	task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		wt();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		wt();
		rd = hrdata;
	endtask
	task automatic rst(logic h, logic d);
		hresetn <= 1'b0;
		host_mode_select <= h;
		input_divide_select <= d;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (8) @(posedge hclk);
	endtask
	// Exact counts: oscillator period is a whole number of cycles
	task automatic win(logic [2:0] en, logic [31:0] n);
		base = rises;
		repeat (64) @(posedge hclk);
		for (int i = 0; i < 3; i++)
			chk("pci rises", rises[i] - base[i], en[i] ? n : 32'h0);
		chk("sync rises", rises[3] - base[3], n);
	endtask
	////////////////////////////////////////
	initial
	begin
		rst(1'b1, 1'b0);
		foreach (rows[i])
		begin
			bus(1'b1, 32'h0, 32'(rows[i].en));
			bus(1'b0, 32'h0, 32'h0);
			chk("control", rd, rows[i].exp);
			repeat (48) @(posedge hclk);
			win(rows[i].en, 32'h4);
		end
		bus(1'b0, 32'h4, 32'h0);
		chk("status", rd & 32'h1f, 32'h1d);
		bus(1'b1, 32'h4, 32'h0);
		bus(1'b1, 32'h8, 32'h5);
		bus(1'b0, 32'h8, 32'h0);
		chk("unmapped", rd, 32'h0);
		bus(1'b0, 32'h0, 32'h0);
		chk("control kept", rd, 32'h7);
		rst(1'b1, 1'b1);
		chk("pci after reset", 32'(pci_clock_out), 32'h0);
		bus(1'b0, 32'h0, 32'h0);
		chk("control reset", rd, 32'h0);
		bus(1'b0, 32'h4, 32'h0);
		chk("status div", rd & 32'h1f, 32'h3);
		win(3'h0, 32'h2);
		bus(1'b1, 32'h0, 32'h7);
		repeat (48) @(posedge hclk);
		win(3'h7, 32'h2);
		rst(1'b0, 1'b0);
		bus(1'b1, 32'h0, 32'h7);
		repeat (48) @(posedge hclk);
		win(3'h7, 32'h0);
		bus(1'b0, 32'h4, 32'h0);
		chk("status agent", rd & 32'h1f, 32'h0);
		print_verdict();
	end
endmodule
